// *** temp_sensor_status_config_tb_top.sv ***
// Testbench of the sensor register block with a bus host and a result model.
// Assumes short conversion counts set below; limits keep their reset values.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_status_config_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ptr_wr, data_wr, data_rd, conv_on, crit_o, lim_o;
    logic [7:0]  ptr_data, wdata, rdata, q, e;
    logic [15:0] v = '0;
    logic [7:0]  dflt [8] = '{8'h00, 8'h20, 8'h00, 8'h05, 8'h00, 8'h49, 8'h80, 8'h05};
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;
    always #4 clk = ~clk;
    localparam int CONT = 20, ONESHOT = 30, SPS_CONV = 10, SPS_PERIOD = 40;
    tsc_sensor_regs #(.CONT_CYC(CONT), .ONESHOT_CYC(ONESHOT), .SPS_CONV_CYC(SPS_CONV),
        .SPS_PERIOD_CYC(SPS_PERIOD))
    tsc_sensor_regs_i (.clk(clk), .rst(rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
        .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .rdata(rdata),
        .adc_result(v), .converter_on(conv_on), .critical_alarm_output(crit_o),
        .limit_alarm_output(lim_o));
    tsc_host tsc_host_i (.clk(clk), .ptr_wr(ptr_wr), .ptr_data(ptr_data), .data_wr(data_wr),
        .data_rd(data_rd), .wdata(wdata), .rdata(rdata));
    // Status model from the reset limits
    function automatic logic [7:0] st(logic [15:0] t, logic r);
        st = {r, t > 16'h4980, t > 16'h2000, t < 16'h0500, 4'h0};
    endfunction
    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
        n_tests++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        tsc_host_i.ptr(a);
        tsc_host_i.xfer(1'b0, 8'h00, d);
    endtask
    task automatic wr(input logic [7:0] d);
        tsc_host_i.ptr(8'h03);
        tsc_host_i.xfer(1'b1, d, q);
    endtask
    task automatic temp(input logic [7:0] lo);
        rd(8'h00, q);
        chk("temp msb", v[15:8], q);
        tsc_host_i.xfer(1'b0, 8'h00, q);
        chk("temp lsb", lo, q);
    endtask
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            results();
        end
    end
    initial
    begin
        void'($urandom(63343));
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        tsc_host_i.ptr(8'h03);
        foreach (dflt[i])
        begin
            tsc_host_i.xfer(1'b0, 8'h00, q);
            chk("default", dflt[i], q);
        end
        rd(8'h0c, q);
        chk("unmapped", 8'h00, q);
        // One-shot, 13-bit, interrupt mode, above high limit
        v = 16'h2100 + 16'($urandom_range(16'h2700));
        wr(8'h20);
        repeat (40) @(posedge clk) #1;
        chk("idle", 8'h00, {7'h0, conv_on});
        chk("int pin", 8'h00, {7'h0, lim_o});
        e = st(v, 1'b0);
        temp({v[7:3], e[6:4]});
        rd(8'h02, q);
        chk("status", st(v, 1'b1), q);
        chk("int pin", 8'h01, {7'h0, lim_o});
        // One-shot, 16-bit, comparator, active high, below low limit
        v = 16'($urandom_range(16'h04ff));
        wr(8'hbc);
        repeat (40) @(posedge clk) #1;
        rd(8'h02, q);
        chk("status", st(v, 1'b0), q);
        chk("cmp pins", 8'h01, {6'h0, crit_o, lim_o});
        wr(8'hbc);
        rd(8'h02, q);
        chk("status", 8'h80, q);
        repeat (40) @(posedge clk) #1;
        temp(v[7:0]);
        // Continuous, four faults, comparator, active low, above critical
        v = 16'h4a00 + 16'($urandom_range(16'h0fff));
        wr(8'h13);
        repeat (70) @(posedge clk) #1;
        chk("three faults", 8'h03, {6'h0, crit_o, lim_o});
        repeat (25) @(posedge clk) #1;
        chk("four faults", 8'h00, {6'h0, crit_o, lim_o});
        temp({v[7:3], 3'b110});
        chk("running", 8'h01, {7'h0, conv_on});
        // Once per second, interrupt mode, critical latch still set from above
        repeat (20) @(posedge clk) #1;
        wr(8'h40);
        chk("crit int", 8'h00, {7'h0, crit_o});
        rd(8'h02, q);
        chk("sps status", st(v, 1'b1), q);
        chk("crit int", 8'h01, {7'h0, crit_o});
        repeat (20) @(posedge clk) #1;
        chk("sps wait", 8'h01, {7'h0, conv_on});
        rd(8'h02, q);
        chk("sps result", st(v, 1'b0), q);
        temp({v[7:3], 3'b110});
        rd(8'h02, q);
        chk("sps idle", 8'h80, q);
        wr(8'h60);
        @(posedge clk) #1;
        chk("shutdown", 8'h00, {7'h0, conv_on});
        rd(8'h03, q);
        chk("cfg", 8'h60, q);
        results();
    end
endmodule
`default_nettype wire

// *** tsc_consts.svh ***
// Offsets, field positions, reset values and timing counts of the sensor registers.
// Assumes inclusion by bare name; definitions only.
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

`define TSC_ADDR_TEMP_MSB   8'h00
`define TSC_ADDR_TEMP_LSB   8'h01
`define TSC_ADDR_STATUS     8'h02
`define TSC_ADDR_CONFIG     8'h03
`define TSC_ADDR_HIGH_MSB   8'h04
`define TSC_ADDR_HIGH_LSB   8'h05
`define TSC_ADDR_LOW_MSB    8'h06
`define TSC_ADDR_LOW_LSB    8'h07
`define TSC_ADDR_CRIT_MSB   8'h08
`define TSC_ADDR_CRIT_LSB   8'h09
`define TSC_ADDR_HYST       8'h0a

`define TSC_CFG_FAULT_LSB   0
`define TSC_CFG_CRIT_POL    2
`define TSC_CFG_LIMIT_POL   3
`define TSC_CFG_CMP_MODE    4
`define TSC_CFG_MODE_LSB    5
`define TSC_CFG_RES16       7

`define TSC_MODE_CONT       2'h0
`define TSC_MODE_ONESHOT    2'h1
`define TSC_MODE_SPS        2'h2
`define TSC_MODE_SHUTDOWN   2'h3

`define TSC_CH_LOW          0
`define TSC_CH_HIGH         1
`define TSC_CH_CRIT         2

`define TSC_RST_CONFIG      8'h00
`define TSC_RST_HIGH        16'h2000
`define TSC_RST_LOW         16'h0500
`define TSC_RST_CRIT        16'h4980
`define TSC_RST_HYST        8'h05

`define TSC_TIMER_W         27
`define TSC_CLK_KHZ         125000
`define TSC_CONT_MS         240
`define TSC_ONESHOT_MS      240
`define TSC_SPS_CONV_MS     60
`define TSC_SPS_PERIOD_MS   1000
`define TSC_CONT_CYC        (`TSC_CONT_MS * `TSC_CLK_KHZ)
`define TSC_ONESHOT_CYC     (`TSC_ONESHOT_MS * `TSC_CLK_KHZ)
`define TSC_SPS_CONV_CYC    (`TSC_SPS_CONV_MS * `TSC_CLK_KHZ)
`define TSC_SPS_PERIOD_CYC  (`TSC_SPS_PERIOD_MS * `TSC_CLK_KHZ)

`endif

// *** tsc_host.sv ***
// Bus host model: pointer loads, then single-byte reads or writes.
// Assumes the register block samples its strobes on the rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module tsc_host (
    input  wire logic       clk,
    output logic            ptr_wr,
    output logic      [7:0] ptr_data,
    output logic            data_wr,
    output logic            data_rd,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial
    begin
        {ptr_wr, data_wr, data_rd, ptr_data, wdata} = '0;
    end
    task automatic ptr(input logic [7:0] a);
        @(posedge clk) #1;
        ptr_wr = 1'b1;
        ptr_data = a;
        @(posedge clk) #1;
        ptr_wr = 1'b0;
        ptr_data = ~a; // Released lines must not keep the old value
    endtask
    // One pointer load serves MSB then LSB
    task automatic xfer(input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk) #1;
        data_wr = w;
        data_rd = !w;
        wdata = d;
        @(posedge clk) #1;
        {data_wr, data_rd} = 2'b00;
        wdata = ~d;
        q = rdata;
    endtask
endmodule
`default_nettype wire

// *** tsc_limit_chan.sv ***
// One limit channel: event level with hysteresis and a fault-queue qualifier.
// Assumes trip and release are evaluated on the result that result_valid marks.
`timescale 1ns/1ps
`default_nettype none

module tsc_limit_chan (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       result_valid,
    input  wire logic       trip,
    input  wire logic       release_cond,
    input  wire logic [1:0] fault_need,
    output logic            evt,
    output logic            hit,
    output logic            qual,
    output logic            qual_rise
);

    tsc_pkg::tsc_chan_t st;
    tsc_pkg::tsc_chan_t next_st;
    logic [2:0]         cnt_inc;
    logic [2:0]         need;

    assign need    = {1'b0, fault_need} + 3'h1;
    assign cnt_inc = (st.cnt == 3'h4) ? 3'h4 : st.cnt + 3'h1;

    always_comb
    begin
        next_st           = st;
        next_st.hit       = 1'b0;
        next_st.qual_rise = 1'b0;
        if (result_valid)
        begin
            if (trip)
            begin
                next_st.cnt = cnt_inc;
                next_st.evt = 1'b1;
                next_st.hit = 1'b1;
                // Consecutive faults only; one clean result restarts the count
                if ((cnt_inc >= need) && !st.qual) // [R12]
                begin
                    next_st.qual      = 1'b1;
                    next_st.qual_rise = 1'b1;
                end
            end
            else
            begin
                next_st.cnt = 3'h0;
                if (release_cond) // [R21]
                begin
                    next_st.evt  = 1'b0;
                    next_st.qual = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign evt       = st.evt;
    assign hit       = st.hit;
    assign qual      = st.qual;
    assign qual_rise = st.qual_rise;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_short_fault;
        result_valid && trip && (cnt_inc < need);
    endsequence

    fault_queue_hold_a: assert property (s_short_fault |=> !qual_rise) // [R12]
        else $error("alarm qualified before fault count reached");
    fault_queue_fire_a: assert property (
        result_valid && trip && (cnt_inc >= need) && !qual |=> qual_rise && qual) // [R12]
        else $error("alarm not qualified at fault count");
    hyst_release_a: assert property (
        result_valid && !trip && release_cond |=> !evt && !qual) // [R21]
        else $error("event not ended past hysteresis");

endmodule

`default_nettype wire

// *** tsc_pkg.sv ***
// Types of the sensor register block: conversion states and module state records.
// Assumes tsc_consts.svh is compiled alongside for the numeric constants.
package tsc_pkg;

    typedef enum logic [1:0] {
        TSC_CV_IDLE,
        TSC_CV_BUSY,
        TSC_CV_WAIT
    } tsc_conv_state_t;

    typedef struct packed {
        logic       evt;
        logic [2:0] cnt;
        logic       qual;
        logic       hit;
        logic       qual_rise;
    } tsc_chan_t;

    typedef struct packed {
        logic [7:0]      ptr;
        logic [7:0]      rdata;
        logic [7:0]      cfg;
        logic [15:0]     high_lim;
        logic [15:0]     low_lim;
        logic [15:0]     crit_lim;
        logic [7:0]      hyst;
        logic [15:0]     temp;
        logic [2:0]      stat;
        logic            rdy;
        tsc_conv_state_t cv;
        logic [26:0]     timer;
        logic            result;
        logic            limit_irq;
        logic            crit_irq;
        logic            limit_pin;
        logic            crit_pin;
    } tsc_state_t;

endpackage

// *** tsc_sensor_regs.sv ***
// Register and conversion-control logic of the temperature sensor core.
// Assumes a serial bus front end giving pointer, read and write strobes on clk,
// and a converter whose adc_result is stable on clk.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_consts.svh"

// Functional notes
// R01: In 13-bit mode low byte bit 0 shows the below-low-limit event.
// R02: In 13-bit mode low byte bit 1 shows the above-high-limit event.
// R03: In 13-bit mode low byte bit 2 shows the above-critical-limit event.
// R04: In 16-bit mode low byte bits 0 to 2 carry conversion LSBs.
// R05: Low byte bits 3 to 7 are read-only temperature bits, reset zero.
// R06: Status limit flags clear on status read or when condition ends.
// R07: Ready bit 7 drops on new result, returns high on temperature read.
// R08: In one-shot and once-per-second modes a mode write also raises ready.
// R09: Status bit 4 flags below-low; bits 0 to 3 read zero.
// R10: Status bit 5 flags above-high, cleared by read or hysteresis return.
// R11: Status bit 6 flags above-critical, cleared by read or hysteresis return.
// R12: Config bits 1:0 set one to four faults before alarms assert.
// R13: Config bit 2 sets critical alarm polarity, zero active low.
// R14: Config bit 3 sets limit alarm polarity, zero active low.
// R15: Config bit 4 selects comparator (1) or interrupt (0) alarm behaviour.
// R16: Mode 00 converts continuously, restarting at each finish.
// R17: Mode 01 performs one conversion of 240 ms.
// R18: Mode 10 converts once per second for 60 ms each.
// R19: Mode 11 stops conversion; registers stay accessible.
// R20: Config bit 7 selects 13-bit or 16-bit resolution.
// R21: Hysteresis in whole degrees widens the release point of each limit.
// R22: Pointer auto-increments after each data access, high byte then low.
// R23: Comparator alarms follow the condition; interrupt alarms hold until status read.
module tsc_sensor_regs #(
    parameter int CONT_CYC       = `TSC_CONT_CYC,
    parameter int ONESHOT_CYC    = `TSC_ONESHOT_CYC,
    parameter int SPS_CONV_CYC   = `TSC_SPS_CONV_CYC,
    parameter int SPS_PERIOD_CYC = `TSC_SPS_PERIOD_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ptr_wr,
    input  wire logic [7:0]  ptr_data,
    input  wire logic        data_wr,
    input  wire logic        data_rd,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    input  wire logic [15:0] adc_result,
    output logic             converter_on,
    output logic             critical_alarm_output,
    output logic             limit_alarm_output
);

    localparam logic [26:0] CONT_LOAD     = 27'(CONT_CYC - 1);
    localparam logic [26:0] ONESHOT_LOAD  = 27'(ONESHOT_CYC - 1);
    localparam logic [26:0] SPS_CONV_LOAD = 27'(SPS_CONV_CYC - 1);
    localparam logic [26:0] SPS_IDLE_LOAD = 27'(SPS_PERIOD_CYC - SPS_CONV_CYC - 1);

    tsc_pkg::tsc_state_t st;
    tsc_pkg::tsc_state_t next_st;

    logic        rd_ok;
    logic        wr_ok;
    logic        temp_read;
    logic        status_read;
    logic        cfg_write;
    logic        conv_done;
    logic [1:0]  mode;
    logic [1:0]  new_mode;
    logic [7:0]  lowbyte;
    logic [7:0]  status_byte;
    logic [7:0]  read_mux;
    logic [16:0] t17;
    logic [16:0] hyst17;
    logic [16:0] low_rel;
    logic [16:0] high_rel;
    logic [16:0] crit_rel;
    logic [2:0]  trip;
    logic [2:0]  release_cond;
    logic [2:0]  evt;
    logic [2:0]  hit;
    logic [2:0]  qual;
    logic [2:0]  qual_rise;
    logic        limit_active;
    logic        crit_active;

    // A pointer load in the same cycle takes priority; data strobes are dropped
    assign rd_ok       = data_rd && !ptr_wr;
    assign wr_ok       = data_wr && !data_rd && !ptr_wr;
    assign temp_read   = rd_ok && (st.ptr == `TSC_ADDR_TEMP_MSB || st.ptr == `TSC_ADDR_TEMP_LSB);
    assign status_read = rd_ok && (st.ptr == `TSC_ADDR_STATUS);
    assign cfg_write   = wr_ok && (st.ptr == `TSC_ADDR_CONFIG);
    assign mode        = st.cfg[`TSC_CFG_MODE_LSB +: 2];
    assign new_mode    = wdata[`TSC_CFG_MODE_LSB +: 2];
    assign conv_done   = (st.cv == tsc_pkg::TSC_CV_BUSY) && (st.timer == 27'h0);

    // Flags sit in bits 2:0 only in 13-bit mode
    assign lowbyte = st.cfg[`TSC_CFG_RES16] ? st.temp[7:0] // [R04] [R20]
                   : {st.temp[7:3], evt[`TSC_CH_CRIT], evt[`TSC_CH_HIGH], evt[`TSC_CH_LOW]}; // [R01] [R02] [R03] [R05]
    assign status_byte = {st.rdy, st.stat, 4'h0}; // [R09]

    // All limits compared on one 1/128 degree scale; release points one bit wider to avoid wrap
    assign t17      = {st.temp[15], st.temp};
    assign hyst17   = {6'h00, st.hyst[3:0], 7'h00};
    assign low_rel  = {st.low_lim[15], st.low_lim} + hyst17; // [R21]
    assign high_rel = {st.high_lim[15], st.high_lim} - hyst17; // [R21]
    assign crit_rel = {st.crit_lim[15], st.crit_lim} - hyst17; // [R21]

    assign trip[`TSC_CH_LOW]          = $signed(st.temp) < $signed(st.low_lim);
    assign trip[`TSC_CH_HIGH]         = $signed(st.temp) > $signed(st.high_lim);
    assign trip[`TSC_CH_CRIT]         = $signed(st.temp) > $signed(st.crit_lim);
    assign release_cond[`TSC_CH_LOW]  = $signed(t17) > $signed(low_rel);
    assign release_cond[`TSC_CH_HIGH] = $signed(t17) < $signed(high_rel);
    assign release_cond[`TSC_CH_CRIT] = $signed(t17) < $signed(crit_rel);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_chan
            tsc_limit_chan u_chan (
                .clk          (clk),
                .rst          (rst),
                .result_valid (st.result),
                .trip         (trip[gi]),
                .release_cond (release_cond[gi]),
                .fault_need   (st.cfg[`TSC_CFG_FAULT_LSB +: 2]),
                .evt          (evt[gi]),
                .hit          (hit[gi]),
                .qual         (qual[gi]),
                .qual_rise    (qual_rise[gi])
            );
        end
    endgenerate

    always_comb
    begin
        read_mux = 8'h00;
        case (st.ptr)
            `TSC_ADDR_TEMP_MSB: read_mux = st.temp[15:8];
            `TSC_ADDR_TEMP_LSB: read_mux = lowbyte;
            `TSC_ADDR_STATUS:   read_mux = status_byte;
            `TSC_ADDR_CONFIG:   read_mux = st.cfg;
            `TSC_ADDR_HIGH_MSB: read_mux = st.high_lim[15:8];
            `TSC_ADDR_HIGH_LSB: read_mux = st.high_lim[7:0];
            `TSC_ADDR_LOW_MSB:  read_mux = st.low_lim[15:8];
            `TSC_ADDR_LOW_LSB:  read_mux = st.low_lim[7:0];
            `TSC_ADDR_CRIT_MSB: read_mux = st.crit_lim[15:8];
            `TSC_ADDR_CRIT_LSB: read_mux = st.crit_lim[7:0];
            `TSC_ADDR_HYST:     read_mux = st.hyst;
            default:            read_mux = 8'h00;
        endcase
    end

    always_comb
    begin
        next_st        = st;
        next_st.result = 1'b0;

        // Bus side
        if (ptr_wr)
            next_st.ptr = ptr_data;
        else if (rd_ok || wr_ok)
            next_st.ptr = st.ptr + 8'h01; // [R22]
        if (rd_ok)
            next_st.rdata = read_mux;
        if (wr_ok)
        begin
            case (st.ptr)
                `TSC_ADDR_CONFIG:   next_st.cfg = wdata;
                `TSC_ADDR_HIGH_MSB: next_st.high_lim[15:8] = wdata;
                `TSC_ADDR_HIGH_LSB: next_st.high_lim[7:0] = wdata;
                `TSC_ADDR_LOW_MSB:  next_st.low_lim[15:8] = wdata;
                `TSC_ADDR_LOW_LSB:  next_st.low_lim[7:0] = wdata;
                `TSC_ADDR_CRIT_MSB: next_st.crit_lim[15:8] = wdata;
                `TSC_ADDR_CRIT_LSB: next_st.crit_lim[7:0] = wdata;
                `TSC_ADDR_HYST:     next_st.hyst = wdata;
                default:            next_st.hyst = st.hyst;
            endcase
        end

        // Conversion sequencer
        case (st.cv)
            tsc_pkg::TSC_CV_IDLE:
            begin
                if (mode == `TSC_MODE_CONT)
                begin
                    next_st.cv    = tsc_pkg::TSC_CV_BUSY;
                    next_st.timer = CONT_LOAD;
                end
            end
            tsc_pkg::TSC_CV_BUSY:
            begin
                if (st.timer != 27'h0)
                    next_st.timer = st.timer - 27'h1;
                else
                begin
                    next_st.result = 1'b1;
                    next_st.temp   = st.cfg[`TSC_CFG_RES16] ? adc_result // [R20]
                                   : {adc_result[15:3], 3'h0};
                    case (mode)
                        `TSC_MODE_CONT:
                        begin
                            next_st.timer = CONT_LOAD; // [R16]
                        end
                        `TSC_MODE_SPS:
                        begin
                            next_st.cv    = tsc_pkg::TSC_CV_WAIT; // [R18]
                            next_st.timer = SPS_IDLE_LOAD;
                        end
                        default:
                        begin
                            next_st.cv = tsc_pkg::TSC_CV_IDLE; // [R17]
                        end
                    endcase
                end
            end
            tsc_pkg::TSC_CV_WAIT:
            begin
                if (st.timer != 27'h0)
                    next_st.timer = st.timer - 27'h1;
                else
                begin
                    next_st.cv    = tsc_pkg::TSC_CV_BUSY; // [R18]
                    next_st.timer = SPS_CONV_LOAD;
                end
            end
            default:
            begin
                next_st.cv = tsc_pkg::TSC_CV_IDLE;
            end
        endcase
        if (mode == `TSC_MODE_SHUTDOWN)
            next_st.cv = tsc_pkg::TSC_CV_IDLE; // [R19]

        // Rewriting the same continuous or ONCE_PER_SECOND_MODE mode leaves the cycle running
        if (cfg_write && (new_mode != mode || new_mode == `TSC_MODE_ONESHOT))
        begin
            case (new_mode)
                `TSC_MODE_CONT:
                begin
                    next_st.cv    = tsc_pkg::TSC_CV_BUSY; // [R16]
                    next_st.timer = CONT_LOAD;
                end
                `TSC_MODE_ONESHOT:
                begin
                    next_st.cv    = tsc_pkg::TSC_CV_BUSY; // [R17]
                    next_st.timer = ONESHOT_LOAD;
                end
                `TSC_MODE_SPS:
                begin
                    next_st.cv    = tsc_pkg::TSC_CV_BUSY; // [R18]
                    next_st.timer = SPS_CONV_LOAD;
                end
                default:
                begin
                    next_st.cv = tsc_pkg::TSC_CV_IDLE; // [R19]
                end
            endcase
        end

        // Ready: a fresh result beats a coinciding read
        if (next_st.result)
            next_st.rdy = 1'b0; // [R07]
        else if (temp_read)
            next_st.rdy = 1'b1; // [R07]
        else if (cfg_write && (new_mode == `TSC_MODE_ONESHOT || new_mode == `TSC_MODE_SPS))
            next_st.rdy = 1'b1; // [R08]

        // Status flags: a hit in the clearing cycle survives
        next_st.stat = hit | (st.stat & evt & {3{!status_read}}); // [R06] [R09] [R10] [R11]

        next_st.limit_irq = qual_rise[`TSC_CH_LOW] || qual_rise[`TSC_CH_HIGH]
                          || (st.limit_irq && !status_read); // [R23]
        next_st.crit_irq  = qual_rise[`TSC_CH_CRIT] || (st.crit_irq && !status_read); // [R23]
        // Comparator follows the qualified level; interrupt mode uses the latch
        limit_active = next_st.cfg[`TSC_CFG_CMP_MODE] // [R15] [R23]
                     ? (qual[`TSC_CH_LOW] || qual[`TSC_CH_HIGH]) : next_st.limit_irq;
        crit_active  = next_st.cfg[`TSC_CFG_CMP_MODE] // [R15] [R23]
                     ? qual[`TSC_CH_CRIT] : next_st.crit_irq;
        next_st.limit_pin = next_st.cfg[`TSC_CFG_LIMIT_POL] ? limit_active : !limit_active; // [R14]
        next_st.crit_pin  = next_st.cfg[`TSC_CFG_CRIT_POL] ? crit_active : !crit_active; // [R13]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st           <= '0;
            st.cfg       <= `TSC_RST_CONFIG;
            st.high_lim  <= `TSC_RST_HIGH;
            st.low_lim   <= `TSC_RST_LOW;
            st.crit_lim  <= `TSC_RST_CRIT;
            st.hyst      <= `TSC_RST_HYST;
            st.rdy       <= 1'b1;
            st.cv        <= tsc_pkg::TSC_CV_IDLE;
            st.limit_pin <= 1'b1;
            st.crit_pin  <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign rdata                 = st.rdata;
    assign converter_on          = (st.cv != tsc_pkg::TSC_CV_IDLE);
    assign critical_alarm_output = st.crit_pin;
    assign limit_alarm_output    = st.limit_pin;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_temp_read;
        temp_read && !conv_done;
    endsequence

    sequence s_status_read_quiet;
        status_read && (hit == 3'h0);
    endsequence

    rdy_drop_a: assert property (conv_done |=> st.result && !st.rdy) // [R07]
        else $error("ready not lowered on new result");
    rdy_return_a: assert property (s_temp_read |=> st.rdy) // [R07]
        else $error("ready not raised by temperature read");
    rdy_mode_write_a: assert property (
        cfg_write && !conv_done && new_mode == `TSC_MODE_SPS |=> st.rdy) // [R08]
        else $error("ready not raised by mode write");
    stat_read_clear_a: assert property (s_status_read_quiet |=> st.stat == 3'h0) // [R06]
        else $error("status flags survive a quiet status read");
    stat_set_a: assert property (hit != 3'h0 |=> (st.stat & $past(hit)) == $past(hit)) // [R09]
        else $error("limit hit did not set status flag");
    stat_read_bits_a: assert property (
        rd_ok && st.ptr == `TSC_ADDR_STATUS |=> rdata[3:0] == 4'h0 && rdata[7] == $past(st.rdy)) // [R09]
        else $error("status read shows wrong low bits or ready");
    lowbyte_13_a: assert property (
        rd_ok && st.ptr == `TSC_ADDR_TEMP_LSB && !st.cfg[`TSC_CFG_RES16]
        |=> rdata[2:0] == $past(evt)) // [R01]
        else $error("13-bit low byte does not carry event flags");
    lowbyte_16_a: assert property (
        rd_ok && st.ptr == `TSC_ADDR_TEMP_LSB && st.cfg[`TSC_CFG_RES16]
        |=> rdata == $past(st.temp[7:0])) // [R04]
        else $error("16-bit low byte does not carry conversion bits");
    ptr_incr_a: assert property (rd_ok |=> st.ptr == $past(st.ptr) + 8'h01) // [R22]
        else $error("pointer did not advance after read");
    cont_restart_a: assert property (
        conv_done && mode == `TSC_MODE_CONT && !cfg_write
        |=> st.cv == tsc_pkg::TSC_CV_BUSY && st.timer == CONT_LOAD) // [R16]
        else $error("continuous mode did not restart conversion");
    oneshot_stop_a: assert property (
        conv_done && mode == `TSC_MODE_ONESHOT && !cfg_write |=> st.cv == tsc_pkg::TSC_CV_IDLE) // [R17]
        else $error("one-shot did not stop after its result");
    sps_wait_a: assert property (
        conv_done && mode == `TSC_MODE_SPS && !cfg_write |=> st.cv == tsc_pkg::TSC_CV_WAIT) // [R18]
        else $error("once-per-second mode did not wait");
    shutdown_idle_a: assert property (
        mode == `TSC_MODE_SHUTDOWN && !cfg_write |=> !converter_on) // [R19]
        else $error("converter running in shutdown");
    limit_pol_a: assert property (
        st.cfg[`TSC_CFG_CMP_MODE] && !wr_ok
        |=> limit_alarm_output == ($past(qual[`TSC_CH_LOW] || qual[`TSC_CH_HIGH])
                                   ~^ st.cfg[`TSC_CFG_LIMIT_POL])) // [R14]
        else $error("limit alarm level wrong in comparator mode");
    crit_irq_hold_a: assert property (
        !st.cfg[`TSC_CFG_CMP_MODE] && st.crit_irq && !status_read && !wr_ok
        |=> critical_alarm_output == st.cfg[`TSC_CFG_CRIT_POL]) // [R13]
        else $error("critical interrupt alarm released early");

endmodule

`default_nettype wire
